// ### design/aps_host.sv
// Host controller for a 128K x 16 asynchronous pseudo-static RAM.
// Assumes the memory pins are wired straight to the ports; data is split in/out/enable.
// Operation
// - Write strobe stays high throughout reads.
// - No host data drive while memory drives.
// - Invalid address stretch needs proper read cycles.
// - Alternative recovery: primary select high pulse.
// - Write ends when any qualifier goes inactive.
`timescale 1ns/1ps
module aps_host
    import aps_pkg::*;
#(
    parameter int ADDR_W = APS_ADDR_W,
    parameter int DATA_W = APS_DATA_W
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // User request
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [1:0] i_lane,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_recover,
    // User answer
    output logic o_ready,
    output logic o_rvalid,
    output logic [DATA_W-1:0] o_rdata,
    // Memory control pins
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic o_primary_select_n,
    output logic o_secondary_select,
    output logic o_write_n,
    output logic o_gate_n,
    output logic o_upper_lane_enable_n,
    output logic o_lower_lane_enable_n,
    // Memory data pins
    input wire logic [DATA_W-1:0] i_mem_dq,
    output logic [DATA_W-1:0] o_mem_dq,
    output logic o_mem_dq_oe
);

    // ****************************************
    // State
    // ****************************************
    aps_timer_if tif();                 // Phase timer link
    aps_state_t state, next_state;      // Sequencer state
    logic [ADDR_W-1:0] next_mem_addr;   // Address to present
    logic [DATA_W-1:0] next_mem_dq;     // Write data
    logic next_oe;                      // Host drives data
    logic next_psel_n;                  // Primary select
    logic next_ssel;                    // Secondary select
    logic next_write_n;                 // Write strobe
    logic next_gate_n;                  // Output gate
    logic next_upper_n;                 // Upper lane enable
    logic next_lower_n;                 // Lower lane enable
    logic next_ready;                   // Accepting requests
    logic next_rvalid;                  // Read data pulse
    logic [DATA_W-1:0] next_rdata;      // Read data
    logic [1:0] lanes, next_lanes;      // Active lanes of this access
    logic load;                         // Timer load
    logic [APS_CNT_W-1:0] count;        // Timer load value

    // Lane enables from a lane mask; an empty mask would deselect
    function automatic logic [1:0] lane_n(input logic [1:0] m);
        lane_n = (m == 2'h0) ? 2'h0 : ~m;
    endfunction

    // Merge read bytes, undriven lane reads as zero
    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] m,
                                                  input logic [DATA_W-1:0] d);
        lane_mask = {m[1] ? d[DATA_W-1:APS_LANE_W] : 8'h00,
                     m[0] ? d[APS_LANE_W-1:0] : 8'h00};
    endfunction

    aps_timer u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .tif(tif)
    );
    assign tif.load = load;
    assign tif.count = count;

    // ****************************************
    // Sequencer next values
    // ****************************************
    always_comb begin
        next_state = state;
        next_mem_addr = o_mem_addr;
        next_mem_dq = o_mem_dq;
        next_oe = o_mem_dq_oe;
        next_psel_n = o_primary_select_n;
        next_ssel = o_secondary_select;
        next_write_n = o_write_n;
        next_gate_n = o_gate_n;
        next_upper_n = o_upper_lane_enable_n;
        next_lower_n = o_lower_lane_enable_n;
        next_ready = o_ready;
        next_rvalid = 1'h0;
        next_rdata = o_rdata;
        next_lanes = lanes;
        load = 1'h0;
        count = '0;
        unique case (state)
            APS_IDLE: begin
                // Idle shows ready; nothing is taken until ready is seen high
                next_ready = 1'h1;
                if (o_ready && i_recover) begin
                    // Hold primary select high for a full read cycle time
                    next_state = APS_RECOV;
                    next_psel_n = APS_IDLE_HIGH;
                    next_ready = 1'h0;
                    load = 1'h1;
                    count = APS_CNT_W'(APS_RECOVER_CYC);
                end else if (o_ready && i_req) begin
                    next_ready = 1'h0;
                    next_mem_addr = i_addr;
                    next_lanes = (i_lane == 2'h0) ? 2'h3 : i_lane;
                    next_psel_n = 1'h0;
                    next_ssel = 1'h1;
                    {next_upper_n, next_lower_n} = lane_n(i_lane);
                    load = 1'h1;
                    if (i_we) begin
                        // Gate high so the memory never drives during the write
                        next_gate_n = APS_IDLE_HIGH;
                        next_write_n = APS_IDLE_HIGH;
                        next_mem_dq = i_wdata;
                        next_state = APS_WSET;
                        count = APS_CNT_W'(APS_WSETUP_CYC);
                    end else begin
                        // Strobe high, gate low for the whole read
                        next_write_n = APS_IDLE_HIGH;
                        next_gate_n = 1'h0;
                        next_state = APS_RD;
                        count = APS_CNT_W'(APS_RC_CYC);
                    end
                end
            end
            APS_RD: begin
                // Capture at end of a full read cycle, then deselect
                if (tif.done) begin
                    next_rdata = lane_mask(lanes, i_mem_dq);
                    next_rvalid = 1'h1;
                    next_psel_n = APS_IDLE_HIGH;
                    next_ssel = APS_IDLE_LOW;
                    next_gate_n = APS_IDLE_HIGH;
                    next_upper_n = APS_IDLE_HIGH;
                    next_lower_n = APS_IDLE_HIGH;
                    next_ready = 1'h1;
                    next_state = APS_IDLE;
                end
            end
            APS_WSET: begin
                // Drive data and open the write strobe
                if (tif.done) begin
                    next_oe = 1'h1;
                    next_write_n = 1'h0;
                    next_state = APS_WPULSE;
                    load = 1'h1;
                    count = APS_CNT_W'(APS_WP_CYC);
                end
            end
            APS_WPULSE: begin
                // Raising the strobe ends the write and captures data
                if (tif.done) begin
                    next_write_n = APS_IDLE_HIGH;
                    next_state = APS_WHOLD;
                    load = 1'h1;
                    count = APS_CNT_W'(APS_DHOLD_CYC);
                end
            end
            APS_WHOLD: begin
                // Hold data past write end, then release and deselect
                if (tif.done) begin
                    next_oe = 1'h0;
                    next_psel_n = APS_IDLE_HIGH;
                    next_ssel = APS_IDLE_LOW;
                    next_upper_n = APS_IDLE_HIGH;
                    next_lower_n = APS_IDLE_HIGH;
                    next_ready = 1'h1;
                    next_state = APS_IDLE;
                end
            end
            APS_RECOV: begin
                // End of recovery pulse
                if (tif.done) begin
                    next_ready = 1'h1;
                    next_state = APS_IDLE;
                end
            end
            default: begin
                next_state = APS_IDLE;
                next_ready = 1'h1;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= APS_IDLE;
            o_mem_addr <= '0;
            o_mem_dq <= '0;
            o_mem_dq_oe <= 1'h0;
            o_primary_select_n <= APS_IDLE_HIGH;
            o_secondary_select <= APS_IDLE_LOW;
            o_write_n <= APS_IDLE_HIGH;
            o_gate_n <= APS_IDLE_HIGH;
            o_upper_lane_enable_n <= APS_IDLE_HIGH;
            o_lower_lane_enable_n <= APS_IDLE_HIGH;
            o_ready <= 1'h0;
            o_rvalid <= 1'h0;
            o_rdata <= '0;
            lanes <= 2'h0;
        end else if (i_ce) begin
            state <= next_state;
            o_mem_addr <= next_mem_addr;
            o_mem_dq <= next_mem_dq;
            o_mem_dq_oe <= next_oe;
            o_primary_select_n <= next_psel_n;
            o_secondary_select <= next_ssel;
            o_write_n <= next_write_n;
            o_gate_n <= next_gate_n;
            o_upper_lane_enable_n <= next_upper_n;
            o_lower_lane_enable_n <= next_lower_n;
            o_ready <= next_ready;
            o_rvalid <= next_rvalid;
            o_rdata <= next_rdata;
            lanes <= next_lanes;
        end
    end

endmodule

// ### design/aps_pkg.sv
// Package for the asynchronous pseudo-static RAM host controller.
// Assumes a 50 MHz system clock; all timing counts derive from it.
package aps_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int APS_ADDR_W = 17;  // Word address width, 128K words
    localparam int APS_DATA_W = 16;  // Word width
    localparam int APS_LANE_W = 8;   // One byte lane

    // ****************************************
    // Timing
    // ****************************************
    localparam int APS_CLK_PERIOD_NS = 20;  // System clock period
    localparam int APS_RC_NS = 70;          // Read cycle time, slow grade
    localparam int APS_WP_NS = 55;          // Write pulse width
    localparam int APS_WSETUP_NS = 20;      // Bus turnaround before write data
    localparam int APS_DHOLD_NS = 20;       // Data and address hold after write end
    localparam int APS_RECOVER_NS = 70;     // Primary select high recovery pulse
    // Least times, rounded up to whole cycles
    localparam int APS_RC_CYC = (APS_RC_NS + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
    localparam int APS_WP_CYC = (APS_WP_NS + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
    localparam int APS_WSETUP_CYC = (APS_WSETUP_NS + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
    localparam int APS_DHOLD_CYC = (APS_DHOLD_NS + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
    localparam int APS_RECOVER_CYC = (APS_RECOVER_NS + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
    localparam int APS_CNT_W = 4;  // Phase counter width

    // ****************************************
    // Pin idle levels
    // ****************************************
    localparam logic APS_IDLE_HIGH = 1'h1;  // Inactive level of active-low strobes
    localparam logic APS_IDLE_LOW = 1'h0;   // Inactive level of the secondary select

    // ****************************************
    // Controller states, Gray along the usual path
    // ****************************************
    typedef enum logic [2:0] {
        APS_IDLE = 3'h0,
        APS_RD = 3'h4,
        APS_WSET = 3'h1,
        APS_WPULSE = 3'h3,
        APS_WHOLD = 3'h2,
        APS_RECOV = 3'h5
    } aps_state_t;

endpackage

// ### design/aps_timer.sv
// Phase timer: counts down a loaded number of cycles.
// Assumes a synchronous active-low reset and a shared clock enable.
`timescale 1ns/1ps
module aps_timer
    import aps_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Controller side
    aps_timer_if.timer tif
);

    // ****************************************
    // Counter
    // ****************************************
    logic [APS_CNT_W-1:0] remain;       // Cycles left
    logic [APS_CNT_W-1:0] next_remain;  // Next count

    // Load or count down to zero
    always_comb begin
        next_remain = remain;
        if (tif.load) begin
            next_remain = tif.count;
        end else if (remain != '0) begin
            next_remain = remain - 1'h1;
        end
    end

    // Register the counter
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            remain <= '0;
        end else if (i_ce) begin
            remain <= next_remain;
        end
    end

    // Expired in the last cycle of a loaded phase; must not depend on load,
    // since the controller raises load in answer to done
    assign tif.done = (remain == 4'h1);

endmodule

// ### design/aps_timer_if.sv
// Interface joining the host controller to its phase timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface aps_timer_if;
    logic load;                  // Start a new phase
    logic [3:0] count;           // Cycles for the phase
    logic done;                  // Phase has expired
    modport ctrl(output load, output count, input done);
    modport timer(input load, input count, output done);
endinterface

// ### sim/aps_host_chk.sv
// Pin checker for the pseudo-static RAM host controller.
// Assumes one clock domain; bound into every aps_host.
`timescale 1ns/1ps
module aps_host_chk #(
    parameter int ADDR_W = 17
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [1:0] i_lane,
    input wire logic i_recover,
    input wire logic o_ready,
    input wire logic o_rvalid,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic o_primary_select_n,
    input wire logic o_secondary_select,
    input wire logic o_write_n,
    input wire logic o_gate_n,
    input wire logic o_upper_lane_enable_n,
    input wire logic o_lower_lane_enable_n,
    input wire logic o_mem_dq_oe
);
    default clocking cb @(posedge i_clk); endclocking
    // A frozen clock enable stretches every walk, so attempts across it are dropped
    default disable iff (!i_rst_n || !i_ce);
    logic take; // Request accepted at this edge
    logic [1:0] lanes_n; // Expected lane pins
    assign take = i_ce && o_ready && i_req && !i_recover;
    assign lanes_n = (i_lane == 2'h0) ? 2'h0 : ~i_lane;
    sequence rd_hold_s;
        !o_gate_n && o_write_n && !o_primary_select_n && o_secondary_select;
    endsequence
    sequence wr_pulse_s;
        !o_write_n && o_mem_dq_oe && o_gate_n && !o_primary_select_n;
    endsequence
    strobe_in_read_a: assert property (!o_gate_n |-> o_write_n)
        else $error("strobe low in read");
    host_drive_a: assert property (o_mem_dq_oe |-> o_gate_n)
        else $error("host drives with gate low");
    idle_deselect_a: assert property (o_ready |-> o_primary_select_n && !o_secondary_select
        && !o_mem_dq_oe) else $error("not deselected when idle");
    lane_map_a: assert property (take |=>
        {o_upper_lane_enable_n, o_lower_lane_enable_n} == $past(lanes_n)) else $error("lanes");
    read_walk_a: assert property (take && !i_we |=> rd_hold_s[*4] ##1
        (o_rvalid && o_ready && o_gate_n)) else $error("read walk");
    write_walk_a: assert property (take && i_we |=> (o_write_n && !o_mem_dq_oe) ##1
        wr_pulse_s[*3] ##1 (o_write_n && o_mem_dq_oe) ##1 o_ready) else $error("write walk");
    addr_stable_a: assert property (!o_primary_select_n && $past(!o_primary_select_n)
        |-> $stable(o_mem_addr)) else $error("address moved");
    recover_pulse_a: assert property (i_ce && o_ready && i_recover |=>
        (o_primary_select_n && !o_ready)[*4] ##1 o_ready) else $error("recovery pulse");
endmodule
bind aps_host aps_host_chk #(.ADDR_W(ADDR_W)) i_aps_host_chk (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req), .i_we(i_we), .i_lane(i_lane),
    .i_recover(i_recover), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_mem_addr(o_mem_addr),
    .o_primary_select_n(o_primary_select_n), .o_secondary_select(o_secondary_select),
    .o_write_n(o_write_n), .o_gate_n(o_gate_n), .o_upper_lane_enable_n(o_upper_lane_enable_n),
    .o_lower_lane_enable_n(o_lower_lane_enable_n), .o_mem_dq_oe(o_mem_dq_oe));

// ### sim/aps_host_tb.sv
// Self-checking bench for the pseudo-static RAM host controller.
// Assumes the memory model and the bound checker are compiled first.
`timescale 1ns/1ps
module aps_host_tb;
    import aps_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, req = 1'b0, we = 1'b0, rec = 1'b0;
    logic [1:0] lane = 2'h3, drv;
    logic [16:0] addr = 17'h0, maddr;
    logic [15:0] wdata = 16'h0, rdata, mdq, hdq, q;
    logic ready, rvalid, psel_n, ssel, wr_n, gate_n, oe, clash, upn, lon;
    int num_errors = 0, check_count = 0;
    always #10 clk = ~clk;
    aps_host i_aps_host (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_req(req), .i_we(we),
        .i_lane(lane), .i_addr(addr), .i_wdata(wdata), .i_recover(rec), .o_ready(ready),
        .o_rvalid(rvalid), .o_rdata(rdata), .o_mem_addr(maddr), .o_primary_select_n(psel_n),
        .o_secondary_select(ssel), .o_write_n(wr_n), .o_gate_n(gate_n),
        .o_upper_lane_enable_n(upn), .o_lower_lane_enable_n(lon),
        .i_mem_dq(mdq), .o_mem_dq(hdq), .o_mem_dq_oe(oe));
    aps_mem_model i_aps_mem_model (.i_addr(maddr), .i_psel_n(psel_n), .i_ssel(ssel),
        .i_write_n(wr_n), .i_gate_n(gate_n), .i_lane_n({upn, lon}), .i_host_dq(hdq),
        .i_host_oe(oe), .o_dq(mdq), .o_drv(drv), .o_clash(clash));
    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access, waiting for ready and for read data under a bound
    task automatic acc(input logic w, input logic [1:0] l, input logic [16:0] a,
        input logic [15:0] d);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 20) check(16'(n), 16'h0);
        {req, we, lane, addr, wdata} = {1'b1, w, l, a, d};
        @(posedge clk);
        #1 req = 1'b0;
        n = 0;
        while (!w && rvalid !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        q = rdata;
        if (n >= 20) check(16'(n), 16'h0);
    endtask
    task automatic t_word;
        acc(1'b1, 2'h3, 17'h1FFFF, 16'h1234);
        acc(1'b1, 2'h0, 17'h00000, 16'hA55A);
        acc(1'b0, 2'h3, 17'h1FFFF, 16'h0);
        check(q, 16'h1234);
        acc(1'b0, 2'h3, 17'h00000, 16'h0);
        check(q, 16'hA55A);
        $display("test word done");
    endtask
    task automatic t_bytes;
        acc(1'b1, 2'h3, 17'h0AAAA, 16'hCDEF);
        acc(1'b1, 2'h1, 17'h0AAAA, 16'h1177);
        acc(1'b0, 2'h3, 17'h0AAAA, 16'h0);
        check(q, 16'hCD77);
        acc(1'b1, 2'h2, 17'h0AAAA, 16'h3344);
        acc(1'b0, 2'h3, 17'h0AAAA, 16'h0);
        check(q, 16'h3377);
        acc(1'b0, 2'h1, 17'h0AAAA, 16'h0);
        check(q, 16'h0077);
        acc(1'b0, 2'h2, 17'h0AAAA, 16'h0);
        check(q, 16'h3300);
        $display("test bytes done");
    endtask
    task automatic t_recover;
        int n;
        n = 0;
        rec = 1'b1;
        @(posedge clk);
        #1 rec = 1'b0;
        while (ready !== 1'b1 && n < 20) begin
            check({15'h0, psel_n}, 16'h1);
            @(posedge clk);
            #1 n++;
        end
        check(16'(n), 16'(APS_RECOVER_CYC));
        check({13'h0, clash, drv}, 16'h0);
        $display("test recover done");
    endtask
    // Clock enable low mid-write freezes the pins; the write still lands
    task automatic t_freeze;
        acc(1'b1, 2'h3, 17'h15555, 16'hBEEF);
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 check({12'h0, ready, psel_n, wr_n, oe}, 16'h0002);
        ce = 1'b1;
        acc(1'b0, 2'h3, 17'h15555, 16'h0);
        check(q, 16'hBEEF);
        $display("test freeze done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1 t_word();
        t_bytes();
        t_recover();
        t_freeze();
        tally_and_finish();
    end
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
endmodule

// ### sim/aps_mem_model.sv
// Behavioural model of the 128K x 16 byte-lane pseudo-static RAM.
// Assumes host pins wired straight in; undriven lanes show inverted data.
`timescale 1ns/1ps
module aps_mem_model (
    // Host control pins
    input wire logic [16:0] i_addr,
    input wire logic i_psel_n,
    input wire logic i_ssel,
    input wire logic i_write_n,
    input wire logic i_gate_n,
    input wire logic [1:0] i_lane_n,
    // Host data drive
    input wire logic [15:0] i_host_dq,
    input wire logic i_host_oe,
    // Resolved data wire and status
    output logic [15:0] o_dq,
    output logic [1:0] o_drv,
    output logic o_clash
);
    logic [15:0] mem [0:131071]; // Word store
    logic sel; // Chip selected
    logic wr_act; // Write overlap
    logic [1:0] en; // Lanes enabled
    logic [1:0] lat_en; // Lanes seen while writing
    logic [15:0] lat_d; // Data seen while writing
    logic [16:0] lat_a; // Address seen while writing
    assign en = ~i_lane_n;
    assign sel = !i_psel_n && i_ssel && (en != 2'h0);
    assign o_drv = (sel && i_write_n && !i_gate_n) ? en : 2'h0;
    assign wr_act = sel && !i_write_n;
    initial begin
        o_clash = 1'b0;
        for (int k = 0; k < 131072; k++) mem[k] = 16'h0;
    end
    // Wire level per lane: device, then host, else inverted store
    always @* begin
        o_dq = ~mem[i_addr];
        if (i_host_oe) o_dq = i_host_dq;
        if (o_drv[0]) o_dq[7:0] = mem[i_addr][7:0];
        if (o_drv[1]) o_dq[15:8] = mem[i_addr][15:8];
        if (i_host_oe && o_drv != 2'h0) o_clash = 1'b1;
    end
    // Track qualifiers until the write ends
    always @* begin
        if (wr_act) begin
            lat_en = en;
            lat_d = i_host_dq;
            lat_a = i_addr;
        end
    end
    // Capture on the edge that ends the write
    always @(negedge wr_act) begin
        if (lat_en[0] === 1'b1) mem[lat_a][7:0] = lat_d[7:0];
        if (lat_en[1] === 1'b1) mem[lat_a][15:8] = lat_d[15:8];
    end
endmodule
